//--- design/malu_pkg.sv
/*
  Shared types and constants for the ALU / table-read datapath.
  Assumes one instruction clock and a decoder that issues one op at a time.
*/
package malu_pkg;

  localparam int          MALU_DW        = 8;
  localparam int          MALU_ROM_AW    = 11;
  localparam int          MALU_ROM_DW    = 14;
  localparam int          MALU_RF_AW     = 6;
  localparam int          MALU_PTR_LSB   = 0;
  localparam int          MALU_PTR_W     = 3;
  localparam int          MALU_HI_W      = 6;
  localparam int          MALU_LO_MSB    = 7;
  localparam int          MALU_NIB       = 4;
  localparam logic [7:0]  MALU_ACCUM_RST = 8'h00;
  localparam logic [7:0]  MALU_TMD_RST   = 8'h00;
  localparam logic [5:0]  MALU_THD_RST   = 6'h00;
  localparam logic [7:0]  MALU_THP_RST   = 8'h00;
  localparam int          MALU_TBL_CYC   = 2;
  localparam logic        MALU_DEST_ACCUM = 1'b0;
  localparam logic        MALU_DEST_REG   = 1'b1;

  typedef enum logic [2:0] {
    MALU_OP_NONE,
    MALU_OP_SUBI,
    MALU_OP_TBL,
    MALU_OP_SWAP,
    MALU_OP_LDTMD,
    MALU_OP_RDTMD,
    MALU_OP_XORI,
    MALU_OP_XORR
  } malu_op_t;

  typedef struct packed {
    malu_op_t        op;
    logic [7:0]      imm;
    logic [5:0]      raddr;
    logic            dest;
  } malu_cmd_t;

  typedef struct packed {
    logic z;
    logic digit_carry;
    logic c;
  } malu_flags_t;

endpackage : malu_pkg

//--- design/malu_sub8.sv
/*
  Eight-bit subtractor a - b with zero, digit carry and carry; both carries are inverted borrows.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
module malu_sub8 import malu_pkg::*; (
  input  wire logic [7:0] a,      // Minuend
  input  wire logic [7:0] b,      // Subtrahend
  output logic      [7:0] diff,   // Difference
  output malu_flags_t     flags   // Flags of the difference
);
  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    full     = {1'b0, a} + {1'b0, ~b} + 9'h001;
    low      = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    diff     = full[7:0];
    flags.z  = (full[7:0] == 8'h00);
    flags.digit_carry = low[4];
    flags.c  = full[8];
  end
endmodule : malu_sub8

//--- design/malu_zdet.sv
/*
  Zero detector for one byte, used for the result of both XOR forms.
  Combinational only.
*/
`timescale 1ns/1ps
module malu_zdet #(
  parameter int W = 8             // Width of value
) (
  input  wire logic [W-1:0] val,  // Value tested
  output logic              zero  // High when val is all zero
);
  assign zero = (val == '0);
endmodule : malu_zdet

//--- design/malu_core.sv
/*
  Execution datapath for a subset of the instruction set: immediate subtract,
  nibble exchange, XOR immediate / register, timer mode moves and the two-cycle
  ROM table read. Assumes the decoder holds off new commands while busy is high
  and that the register file answers rf_rdata combinationally for cmd.raddr.
  // Function
  // RULE1: Immediate minus accumulator, sets three flags, one cycle
  // RULE2: Carry is inverted borrow on subtraction
  // RULE3: Table read addresses ROM by pointer and accumulator
  // RULE4: Upper six ROM bits load table high data
  // RULE5: Nibble exchange, one cycle, flags unchanged
  // RULE6: Destination bit zero accumulator, one register
  // RULE7: Load timer mode from accumulator, flags kept
  // RULE8: Read timer mode into accumulator, flags kept
  // RULE9: XOR immediate into accumulator, only Z changes
  // RULE10: XOR register to destination, only Z changes
  // RULE11: Unlisted flags hold, both table cycles included
*/
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module malu_core import malu_pkg::*; (
  input  wire logic                   clk,                 // Instruction clock
  input  wire logic                   resetn,              // Async reset, active low
  input  wire logic                   cmd_valid,           // One-cycle op strobe
  input  malu_cmd_t                   cmd,                 // Op, immediate, address, dest
  input  wire logic [7:0]             rf_rdata,            // Addressed register value
  input  wire logic [7:0]             table_high_pointer,  // Pointer for table read
  input  wire logic [MALU_ROM_DW-1:0] rom_data,            // ROM word, valid in the same cycle as rom_addr
  output logic      [MALU_ROM_AW-1:0] rom_addr,            // ROM address
  output logic                        rom_rd,              // ROM read request
  output logic      [7:0]             accumulator,         // Accumulator
  output logic      [7:0]             timer_zero_mode_reg, // Timer-0 mode register
  output logic      [5:0]             table_high_data,     // Table high data
  output malu_flags_t                 flags,               // Zero, digit carry, carry
  output logic                        rf_we,               // Register write strobe
  output logic      [5:0]             rf_waddr,            // Register write address
  output logic      [7:0]             rf_wdata,            // Register write data
  output logic                        busy                 // Table read in flight
);

  // ---------------------------------------------------------------
  // Combinational operators
  // ---------------------------------------------------------------
  logic [7:0]  sub_res;
  malu_flags_t sub_flg;
  logic [7:0]  xor_res;
  logic        xor_zero;
  logic [7:0]  swap_res;

  malu_sub8 u_sub (
    .a     (cmd.imm),
    .b     (accumulator),
    .diff  (sub_res),
    .flags (sub_flg)
  );

  assign xor_res = (cmd.op == MALU_OP_XORI) ? (accumulator ^ cmd.imm) : (accumulator ^ rf_rdata);

  malu_zdet #(.W(MALU_DW)) u_zdet (
    .val  (xor_res),
    .zero (xor_zero)
  );

  assign swap_res = {rf_rdata[MALU_NIB-1:0], rf_rdata[MALU_DW-1:MALU_NIB]};  // [RULE5]

  // ---------------------------------------------------------------
  // Table read sequencer
  // ---------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_FETCH} malu_st_t;
  malu_st_t state_r;
  logic     do_op;
  assign do_op = cmd_valid && (state_r == ST_IDLE);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE:  if (do_op && cmd.op == MALU_OP_TBL) state_r <= ST_FETCH;  // [RULE3]
        ST_FETCH: state_r <= ST_IDLE;
        default:  state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy     <= 1'b0;
      rom_rd   <= 1'b0;
      rom_addr <= '0;
    end else begin
      // Busy spans exactly the fetch cycle, so the decoder can stall on it
      busy   <= do_op && cmd.op == MALU_OP_TBL;
      rom_rd <= do_op && cmd.op == MALU_OP_TBL;
      if (do_op && cmd.op == MALU_OP_TBL) begin
        rom_addr <= {table_high_pointer[MALU_PTR_LSB +: MALU_PTR_W], accumulator};  // [RULE3]
      end
    end
  end

  // ---------------------------------------------------------------
  // Accumulator
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      accumulator <= MALU_ACCUM_RST;
    end else if (state_r == ST_FETCH) begin
      // Fetch cycle wins: a command offered now is refused, never merged
      accumulator <= rom_data[MALU_LO_MSB:0];  // [RULE3]
    end else if (do_op) begin
      case (cmd.op)
        MALU_OP_SUBI:  accumulator <= sub_res;  // [RULE1]
        MALU_OP_RDTMD: accumulator <= timer_zero_mode_reg;  // [RULE8]
        MALU_OP_XORI:  accumulator <= xor_res;  // [RULE9]
        MALU_OP_XORR:  if (cmd.dest == MALU_DEST_ACCUM) accumulator <= xor_res;  // [RULE6] [RULE10]
        MALU_OP_SWAP:  if (cmd.dest == MALU_DEST_ACCUM) accumulator <= swap_res;  // [RULE6] [RULE5]
        default:       accumulator <= accumulator;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Table high data and timer mode
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      table_high_data <= MALU_THD_RST;
    end else if (state_r == ST_FETCH) begin
      table_high_data <= rom_data[MALU_ROM_DW-1:MALU_DW];  // [RULE4]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_zero_mode_reg <= MALU_TMD_RST;
    end else if (do_op && cmd.op == MALU_OP_LDTMD) begin
      timer_zero_mode_reg <= accumulator;  // [RULE7]
    end
  end

  // ---------------------------------------------------------------
  // Register file write-back
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rf_we    <= 1'b0;
      rf_waddr <= '0;
      rf_wdata <= 8'h00;
    end else begin
      rf_we    <= do_op && cmd.dest == MALU_DEST_REG &&
                  (cmd.op == MALU_OP_XORR || cmd.op == MALU_OP_SWAP);  // [RULE6]
      // Address and data follow every cycle; only rf_we qualifies them
      rf_waddr <= cmd.raddr;
      rf_wdata <= (cmd.op == MALU_OP_SWAP) ? swap_res : xor_res;  // [RULE5] [RULE10]
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // Only subtraction and XOR touch flags; everything else holds them.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags <= '0;
    end else if (do_op) begin
      case (cmd.op)
        MALU_OP_SUBI: flags <= sub_flg;  // [RULE1] [RULE2]
        MALU_OP_XORI,
        MALU_OP_XORR: flags.z <= xor_zero;  // [RULE9] [RULE10]
        default:      flags <= flags;  // [RULE11]
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence tbl_start_s;
    do_op && cmd.op == MALU_OP_TBL;
  endsequence

  sequence tbl_end_s;
    state_r == ST_FETCH;
  endsequence

  // Operations as they are taken, a command refused in fetch, and idle; each a single cycle

  sequence subi_s;
    do_op && cmd.op == MALU_OP_SUBI;
  endsequence

  sequence swap_s;
    do_op && cmd.op == MALU_OP_SWAP;
  endsequence

  sequence xori_s;
    do_op && cmd.op == MALU_OP_XORI;
  endsequence

  sequence xorr_s;
    do_op && cmd.op == MALU_OP_XORR;
  endsequence

  sequence tmd_move_s;
    do_op && (cmd.op == MALU_OP_LDTMD || cmd.op == MALU_OP_RDTMD);
  endsequence

  sequence fetch_offer_s;
    state_r == ST_FETCH && cmd_valid;
  endsequence

  sequence idle_s;
    state_r == ST_IDLE && !cmd_valid;
  endsequence

  subi_result_a: assert property (do_op && cmd.op == MALU_OP_SUBI |=>  // [RULE1]
    accumulator == 8'($past(cmd.imm) - $past(accumulator))) else $error("subtract result wrong");
  sub_borrow_a: assert property (do_op && cmd.op == MALU_OP_SUBI |=>  // [RULE2]
    flags.c == ($past(cmd.imm) >= $past(accumulator))) else $error("subtract carry wrong");
  tbl_addr_a: assert property (tbl_start_s |=>  // [RULE3]
    rom_addr == {$past(table_high_pointer[2:0]), $past(accumulator)} && busy) else $error("table address wrong");
  tbl_load_a: assert property (tbl_start_s ##1 tbl_end_s |=>  // [RULE4]
    table_high_data == $past(rom_data[13:8]) && accumulator == $past(rom_data[7:0])) else $error("table load wrong");
  swap_nibble_a: assert property (do_op && cmd.op == MALU_OP_SWAP && cmd.dest == MALU_DEST_REG |=>  // [RULE5]
    rf_we && rf_wdata == {$past(rf_rdata[3:0]), $past(rf_rdata[7:4])}) else $error("swap write wrong");
  dest_accum_a: assert property (do_op && cmd.op == MALU_OP_XORR && cmd.dest == MALU_DEST_ACCUM |=>  // [RULE6]
    !rf_we && accumulator == ($past(accumulator) ^ $past(rf_rdata))) else $error("dest select wrong");
  ldtmd_copy_a: assert property (do_op && cmd.op == MALU_OP_LDTMD |=>  // [RULE7]
    timer_zero_mode_reg == $past(accumulator) && $stable(flags)) else $error("timer mode load wrong");
  rdtmd_copy_a: assert property (do_op && cmd.op == MALU_OP_RDTMD |=>  // [RULE8]
    accumulator == $past(timer_zero_mode_reg) && $stable(flags)) else $error("timer mode read wrong");
  xori_zero_a: assert property (do_op && cmd.op == MALU_OP_XORI |=>  // [RULE9]
    flags.z == (accumulator == 8'h00) && flags.c == $past(flags.c)) else $error("xor immediate wrong");
  xorr_flags_a: assert property (do_op && cmd.op == MALU_OP_XORR |=>  // [RULE10]
    flags.digit_carry == $past(flags.digit_carry) && flags.c == $past(flags.c)) else $error("xor register flags wrong");
  tbl_flags_a: assert property (tbl_start_s |=> $stable(flags) ##1 $stable(flags))  // [RULE11]
    else $error("table read changed flags");

  // ---------------------------------------------------------------
  // Further checks
  // ---------------------------------------------------------------

  sub_digit_a: assert property (subi_s |=>  // [RULE1]
    flags.digit_carry == ($past(cmd.imm[3:0]) >= $past(accumulator[3:0])))
    else $error("subtract digit carry wrong");

  sub_zero_a: assert property (subi_s |=>  // [RULE1]
    flags.z == (accumulator == 8'h00) && !busy)
    else $error("subtract zero wrong");

  swap_flags_a: assert property (swap_s |=>  // [RULE5]
    $stable(flags) && !busy)
    else $error("swap changed flags");

  swap_accum_a: assert property (swap_s ##0 (cmd.dest == MALU_DEST_ACCUM) |=>  // [RULE6]
    !rf_we && accumulator == {$past(rf_rdata[3:0]), $past(rf_rdata[7:4])})
    else $error("swap to accumulator wrong");

  xorr_reg_a: assert property (xorr_s ##0 (cmd.dest == MALU_DEST_REG) |=>  // [RULE10]
    rf_we && rf_waddr == $past(cmd.raddr) && $stable(accumulator) &&
    rf_wdata == ($past(accumulator) ^ $past(rf_rdata))) else $error("xor register write wrong");

  xorr_zero_a: assert property (xorr_s |=>  // [RULE10]
    flags.z == (($past(accumulator) ^ $past(rf_rdata)) == 8'h00))
    else $error("xor register zero wrong");

  xori_value_a: assert property (xori_s |=>  // [RULE9]
    accumulator == ($past(accumulator) ^ $past(cmd.imm)) && flags.digit_carry == $past(flags.digit_carry))
    else $error("xor immediate value wrong");

  tmd_hold_a: assert property (tmd_move_s |=>  // [RULE7] [RULE8]
    $stable(flags) && !rf_we && !busy)
    else $error("timer move side effect");

  load_keep_a: assert property (do_op && cmd.op == MALU_OP_LDTMD |=>  // [RULE7]
    $stable(accumulator))
    else $error("timer load changed accumulator");

  read_keep_a: assert property (do_op && cmd.op == MALU_OP_RDTMD |=>  // [RULE8]
    $stable(timer_zero_mode_reg))
    else $error("timer read changed mode");

  tbl_pulse_a: assert property (tbl_start_s |=>  // [RULE3]
    (busy && rom_rd) ##1 (!busy && !rom_rd))
    else $error("table fetch timing wrong");

  fetch_refuse_a: assert property (fetch_offer_s |=>  // [RULE3]
    !rf_we && !busy && $stable(flags) && $stable(timer_zero_mode_reg))
    else $error("op taken during fetch");

  addr_hold_a: assert property (tbl_end_s |=>  // [RULE3]
    $stable(rom_addr))
    else $error("table address moved");

  // Holding checks: flags, accumulator and timer mode hold, and no register write, while idle with no command offered
  idle_hold_a: assert property (idle_s |=>  // [RULE11]
    $stable(flags) && $stable(accumulator) && $stable(timer_zero_mode_reg) && !rf_we)
    else $error("state moved while idle");

  write_source_a: assert property (rf_we |->  // [RULE6]
    $past(do_op) && $past(cmd.dest) == MALU_DEST_REG)
    else $error("register write without request");

endmodule : malu_core

//--- test/tb_top.sv
/*
  Self-checking bench for malu_core: each op kind, flag holding and the table read.
  Assumes the bench is the decoder, register file and ROM, all in one clock.
*/
`timescale 1ns/1ps
module tb_top import malu_pkg::*; ;
  logic                   clk;
  logic                   resetn;
  logic                   cmd_valid;
  malu_cmd_t              cmd;
  logic [7:0]             rf_rdata;
  logic [7:0]             table_high_pointer;
  logic [MALU_ROM_DW-1:0] rom_data;
  logic [MALU_ROM_AW-1:0] rom_addr;
  logic                   rom_rd;
  logic [7:0]             accumulator;
  logic [7:0]             timer_zero_mode_reg;
  logic [5:0]             table_high_data;
  malu_flags_t            flags;
  logic                   rf_we;
  logic [5:0]             rf_waddr;
  logic [7:0]             rf_wdata;
  logic                   busy;
  int                     errors;
  int                     num_checks;
  int                     cycles;

  malu_core dut (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd), .rf_rdata(rf_rdata),
    .table_high_pointer(table_high_pointer), .rom_data(rom_data), .rom_addr(rom_addr), .rom_rd(rom_rd),
    .accumulator(accumulator), .timer_zero_mode_reg(timer_zero_mode_reg), .table_high_data(table_high_data),
    .flags(flags), .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .busy(busy));

  // ----------------------------------------------------------------
  // Clock, reset and timeout
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Whole run is well under a hundred cycles; the ceiling leaves room
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors = errors + 1;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One op issued for one cycle; returns just after the edge that takes it settles
  task automatic go(input malu_op_t op, input logic [7:0] imm, input logic [5:0] ra, input logic d,
                    input logic [7:0] rd);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd       <= '{op: op, imm: imm, raddr: ra, dest: d};
    rf_rdata  <= rd;
    @(posedge clk);
    cmd_valid <= 1'b0;
    rf_rdata  <= ~rd;
    #1;
  endtask : go

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("reset state", {accumulator, timer_zero_mode_reg}, 16'h0000);
    chk("reset low", {table_high_data, flags, busy, rom_rd, rf_we}, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_subi();
    go(MALU_OP_SUBI, 8'h05, 6'h00, 1'b0, 8'h00);
    chk("subi no borrow", {accumulator, 5'h00, flags}, 16'h0503);
    go(MALU_OP_SUBI, 8'h04, 6'h00, 1'b0, 8'h00);
    chk("subi borrow", {accumulator, 5'h00, flags}, 16'hFF00);
    go(MALU_OP_SUBI, 8'hFF, 6'h00, 1'b0, 8'h00);
    chk("subi zero", {accumulator, 5'h00, flags}, 16'h0007);
    $display("test subi done");
  endtask : t_subi

  task automatic t_xori();
    go(MALU_OP_XORI, 8'hF0, 6'h00, 1'b0, 8'h00);
    chk("xori value", {accumulator, 5'h00, flags}, 16'hF003);
    go(MALU_OP_XORI, 8'hF0, 6'h00, 1'b0, 8'h00);
    chk("xori zero", {accumulator, 5'h00, flags}, 16'h0007);
    $display("test xori done");
  endtask : t_xori

  task automatic t_tmd();
    go(MALU_OP_XORI, 8'hAA, 6'h00, 1'b0, 8'h00);
    go(MALU_OP_LDTMD, 8'h00, 6'h00, 1'b0, 8'h00);
    chk("load tmd", {timer_zero_mode_reg, 5'h00, flags}, 16'hAA03);
    go(MALU_OP_XORI, 8'hFF, 6'h00, 1'b0, 8'h00);
    go(MALU_OP_RDTMD, 8'h00, 6'h00, 1'b0, 8'h00);
    chk("read tmd", {accumulator, 5'h00, flags}, 16'hAA03);
    $display("test tmd done");
  endtask : t_tmd

  task automatic t_swap();
    go(MALU_OP_SWAP, 8'h00, 6'h2A, MALU_DEST_REG, 8'hA5);
    chk("swap to reg", {rf_we, 1'b0, rf_waddr, rf_wdata}, 16'hAA5A);
    chk("swap accum kept", {accumulator, 5'h00, flags}, 16'hAA03);
    go(MALU_OP_SWAP, 8'h00, 6'h2A, MALU_DEST_ACCUM, 8'hA5);
    chk("swap to accum", {accumulator, 4'h0, rf_we, flags}, 16'h5A03);
    $display("test swap done");
  endtask : t_swap

  task automatic t_xorr();
    go(MALU_OP_XORR, 8'h00, 6'h15, MALU_DEST_REG, 8'h5A);
    chk("xorr to reg", {rf_we, 1'b0, rf_waddr, rf_wdata}, 16'h9500);
    chk("xorr flags", {accumulator, 5'h00, flags}, 16'h5A07);
    go(MALU_OP_XORR, 8'h00, 6'h15, MALU_DEST_ACCUM, 8'hA5);
    chk("xorr to accum", {accumulator, 4'h0, rf_we, flags}, 16'hFF03);
    $display("test xorr done");
  endtask : t_xorr

  // Second op lands in the fetch cycle and must be dropped; taken, it would set the zero flag
  task automatic t_tbl();
    go(MALU_OP_XORI, 8'hCB, 6'h00, 1'b0, 8'h00);
    @(posedge clk);
    cmd_valid          <= 1'b1;
    cmd                <= '{op: MALU_OP_TBL, imm: 8'h00, raddr: 6'h00, dest: 1'b0};
    table_high_pointer <= 8'hFA;
    @(posedge clk);
    cmd                <= '{op: MALU_OP_XORI, imm: 8'h34, raddr: 6'h00, dest: 1'b0};
    rom_data           <= 14'h35AA;
    #1;
    chk("rom addr", {busy, rom_rd, 3'h0, rom_addr}, 16'hC234);
    @(posedge clk);
    cmd_valid <= 1'b0;
    rom_data  <= ~14'h35AA;
    #1;
    chk("table word", {accumulator, 2'h0, table_high_data}, 16'hAA35);
    chk("table flags", {busy, 12'h000, flags}, 16'h0003);
    @(posedge clk);
    #1;
    chk("refused op", {accumulator, 5'h00, flags}, 16'hAA03);
    $display("test table done");
  endtask : t_tbl

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    errors             = 0;
    num_checks         = 0;
    cycles             = 0;
    resetn             = 1'b0;
    cmd_valid          = 1'b0;
    cmd                = '{op: MALU_OP_NONE, imm: 8'h00, raddr: 6'h00, dest: 1'b0};
    rf_rdata           = 8'h00;
    table_high_pointer = 8'h00;
    rom_data           = 14'h0000;
    @(posedge clk);
    #1;
    t_reset();
    @(posedge clk);
    resetn <= 1'b1;
    t_subi();
    t_xori();
    t_tmd();
    t_swap();
    t_xorr();
    t_tbl();
    close_out();
  end
endmodule : tb_top
